// ===== alc_ctrl.sv
// Ambient light parameter register with two-wire serial access and conversion sequencer.
// Assumes command bits come from logic on the same clock and the converter answers on it.
`timescale 1ns/1ps

module alc_ctrl #(
   parameter logic [6:0] DEV_ADDR  = 7'h2A,  // Arbitrary value
   parameter int         TICK_CYC  = alc_pkg::ALC_BASE_TICK_CYC,
   parameter int         ADC_WIDTH = 16
) (
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 rst_b,
   // Serial bus pins
   input  wire logic                 scl_in,
   input  wire logic                 sda_in,
   output logic                      sda_out,
   output logic                      sda_oe,
   // Command bits
   input  wire logic                 selftimed_en,
   input  wire logic                 als_en,
   input  wire logic                 ambient_one_shot_request,
   // Converter
   output logic                      adc_start,
   output logic                      adc_dark,
   input  wire logic                 adc_done,
   input  wire logic [ADC_WIDTH-1:0] adc_data,
   // Results
   output logic                      osc_en,
   output logic [ADC_WIDTH-1:0]      ambient_result,
   output logic                      ambient_ready
);

   // Elaboration check: the accumulator and counters are sized for these ranges
   if (ADC_WIDTH < 8 || ADC_WIDTH > 24 || TICK_CYC < 1) begin : g_bad_params
      $error("alc_ctrl: unsupported parameter values");
   end

   localparam int ACC_W = ADC_WIDTH + 7;

   // ****************************************
   // Functions
   // ****************************************
   // Base ticks of 1/120 s per sample for each rate code
   function automatic logic [6:0] rate_ticks(input logic [2:0] code);
      unique case (code)
         3'h0: rate_ticks = 7'h78;
         3'h1: rate_ticks = 7'h3C;
         3'h2: rate_ticks = 7'h28;
         3'h3: rate_ticks = 7'h1E;
         3'h4: rate_ticks = 7'h18;
         3'h5: rate_ticks = 7'h14;
         3'h6: rate_ticks = 7'h0F;
         3'h7: rate_ticks = 7'h0C;
      endcase
   endfunction

   function automatic logic [7:0] pack_params(input alc_pkg::alc_params_t p);
      pack_params = 8'(p);
   endfunction

   // ****************************************
   // Reset and pin synchronisers
   // ****************************************
   logic [1:0] rst_pipe;
   logic       rst_n;
   logic [1:0] scl_pipe;
   logic [1:0] sda_pipe;
   logic       scl_d;
   logic       sda_d;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'h1};
      end
   end
   assign rst_n = rst_pipe[1];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         scl_pipe <= 2'h3;
         sda_pipe <= 2'h3;
         scl_d    <= 1'h1;
         sda_d    <= 1'h1;
      end else begin
         scl_pipe <= {scl_pipe[0], scl_in};
         sda_pipe <= {sda_pipe[0], sda_in};
         scl_d    <= scl_pipe[1];
         sda_d    <= sda_pipe[1];
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   assign scl_rise  = scl_pipe[1] & ~scl_d;
   assign scl_fall  = ~scl_pipe[1] & scl_d;
   assign bus_start = scl_pipe[1] & scl_d & sda_d & ~sda_pipe[1];
   assign bus_stop  = scl_pipe[1] & scl_d & ~sda_d & sda_pipe[1];

   // ****************************************
   // Serial slave and parameter register
   // ****************************************
   alc_pkg::alc_bus_state_t bst, next_bst;
   logic [3:0]              bit_cnt, next_bit_cnt;
   logic [7:0]              shreg, next_shreg;
   logic [7:0]              txreg, next_txreg;
   logic [7:0]              ptr, next_ptr;
   logic                    ack_slot, next_ack_slot;
   logic                    next_sda_oe;
   alc_pkg::alc_params_t    shadow, next_shadow;

   always_comb begin
      next_bst      = bst;
      next_bit_cnt  = bit_cnt;
      next_shreg    = shreg;
      next_txreg    = txreg;
      next_ptr      = ptr;
      next_ack_slot = ack_slot;
      next_sda_oe   = sda_oe;
      next_shadow   = shadow;
      if (bus_start) begin
         next_bst      = alc_pkg::I_ADDR;
         next_bit_cnt  = 4'h0;
         next_ack_slot = 1'h0;
         next_sda_oe   = 1'h0;
      end else if (bus_stop) begin
         next_bst    = alc_pkg::I_IDLE;
         next_sda_oe = 1'h0;
      end else if (bst != alc_pkg::I_IDLE && scl_rise) begin
         if (!ack_slot) begin
            next_shreg   = {shreg[6:0], sda_pipe[1]};
            next_bit_cnt = bit_cnt + 4'h1;
         end else if (bst == alc_pkg::I_RD && sda_pipe[1]) begin
            next_bst = alc_pkg::I_IDLE;  // Master ended the read
         end
      end else if (bst != alc_pkg::I_IDLE && scl_fall) begin
         if (!ack_slot && bit_cnt == 4'h8) begin
            next_ack_slot = 1'h1;
            next_bit_cnt  = 4'h0;
            next_sda_oe   = 1'h1;
            unique case (bst)
               alc_pkg::I_ADDR: begin
                  if (shreg[7:1] == DEV_ADDR) begin
                     next_bst = shreg[0] ? alc_pkg::I_RD : alc_pkg::I_PTR;
                  end else begin
                     next_bst    = alc_pkg::I_IDLE;
                     next_sda_oe = 1'h0;
                  end
               end
               alc_pkg::I_PTR: begin
                  next_ptr = shreg;
                  next_bst = alc_pkg::I_WR;
               end
               alc_pkg::I_WR: begin
                  if (ptr == alc_pkg::ALC_PARAM_OFFSET)
                     next_shadow = alc_pkg::alc_params_t'(shreg);
                  next_ptr = ptr + 8'h01;
               end
               default: next_sda_oe = 1'h0;  // Read: master acknowledges
            endcase
         end else if (ack_slot) begin
            next_ack_slot = 1'h0;
            next_sda_oe   = 1'h0;
            if (bst == alc_pkg::I_RD) begin
               next_txreg  = (ptr == alc_pkg::ALC_PARAM_OFFSET) ? pack_params(shadow)
                                                                 : alc_pkg::ALC_UNMAPPED_RD;
               next_sda_oe = ~next_txreg[7];
               next_ptr    = ptr + 8'h01;
            end
         end else if (bst == alc_pkg::I_RD) begin
            next_sda_oe = ~txreg[3'(7 - bit_cnt)];
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bst      <= alc_pkg::I_IDLE;
         bit_cnt  <= 4'h0;
         shreg    <= 8'h00;
         txreg    <= 8'h00;
         ptr      <= 8'h00;
         ack_slot <= 1'h0;
         sda_oe   <= 1'h0;
         sda_out  <= 1'h0;
         shadow   <= alc_pkg::ALC_PARAMS_RST;
      end else begin
         bst      <= next_bst;
         bit_cnt  <= next_bit_cnt;
         shreg    <= next_shreg;
         txreg    <= next_txreg;
         ptr      <= next_ptr;
         ack_slot <= next_ack_slot;
         sda_oe   <= next_sda_oe;
         sda_out  <= 1'h0;  // Open drain: only ever pulls low
         shadow   <= next_shadow;
      end
   end

   // ****************************************
   // Measurement sequencer
   // ****************************************
   alc_pkg::alc_meas_state_t mst, next_mst;
   alc_pkg::alc_params_t     act, next_act;
   logic [ACC_W-1:0]         acc, next_acc;
   logic [ADC_WIDTH-1:0]     dark, next_dark;
   logic [7:0]               conv_cnt, next_conv_cnt;
   logic [31:0]              tick_cnt, next_tick_cnt;
   logic [6:0]               wait_cnt, next_wait_cnt;
   logic                     one_shot, next_one_shot;
   logic                     next_adc_start, next_adc_dark;
   logic [ADC_WIDTH-1:0]     next_result;
   logic                     next_ready;
   logic                     run_on;
   logic [ADC_WIDTH-1:0]     avg_val;

   assign run_on  = selftimed_en & als_en;
   assign avg_val = ADC_WIDTH'(acc >> act.avg);

   always_comb begin
      next_mst       = mst;
      next_act       = act;
      next_acc       = acc;
      next_dark      = dark;
      next_conv_cnt  = conv_cnt;
      next_tick_cnt  = tick_cnt;
      next_wait_cnt  = wait_cnt;
      next_one_shot  = one_shot;
      next_adc_start = 1'h0;
      next_adc_dark  = adc_dark;
      next_result    = ambient_result;
      next_ready     = 1'h0;
      // Parameters are taken over only while self-timed mode is off
      if (!selftimed_en && mst == alc_pkg::M_IDLE)
         next_act = shadow;
      // Dropping either enable ends a self-timed run at once; no result is stored
      if (!one_shot && !run_on && mst != alc_pkg::M_IDLE)
         next_mst = alc_pkg::M_IDLE;
      else begin
         unique case (mst)
            alc_pkg::M_IDLE: begin
               next_acc      = '0;
               next_conv_cnt = 8'h00;
               if (run_on || (!selftimed_en && ambient_one_shot_request)) begin
                  next_one_shot = ~selftimed_en;
                  next_mst      = act.offs ? alc_pkg::M_DARK : alc_pkg::M_CONV;
               end
            end
            alc_pkg::M_WAIT: begin
               next_acc      = '0;
               next_conv_cnt = 8'h00;
               if (tick_cnt == 32'(TICK_CYC - 1)) begin
                  next_tick_cnt = 32'h0;
                  if (wait_cnt == 7'h01)
                     next_mst = act.offs ? alc_pkg::M_DARK : alc_pkg::M_CONV;
                  next_wait_cnt = wait_cnt - 7'h01;
               end else begin
                  next_tick_cnt = tick_cnt + 32'h1;
               end
            end
            alc_pkg::M_DARK: begin
               next_adc_start = 1'h1;
               next_adc_dark  = 1'h1;
               next_mst       = alc_pkg::M_DARK_W;
            end
            alc_pkg::M_DARK_W: begin
               if (adc_done) begin
                  next_dark = adc_data;
                  next_mst  = alc_pkg::M_CONV;
               end
            end
            alc_pkg::M_CONV: begin
               next_adc_start = 1'h1;
               next_adc_dark  = 1'h0;
               next_mst       = alc_pkg::M_CONV_W;
            end
            alc_pkg::M_CONV_W: begin
               if (adc_done) begin
                  next_acc      = acc + ACC_W'(adc_data);
                  next_conv_cnt = conv_cnt + 8'h01;
                  // 2^n conversions per reading
                  next_mst = (next_conv_cnt == (8'h01 << act.avg)) ? alc_pkg::M_STORE
                                                                  : alc_pkg::M_CONV;
               end
            end
            alc_pkg::M_STORE: begin
               // Saturate at zero: a noisy dark reading may exceed a dim scene
               if (act.offs)
                  next_result = (avg_val > dark) ? avg_val - dark : '0;
               else
                  next_result = avg_val;
               next_ready    = 1'h1;
               next_tick_cnt = 32'h0;
               next_wait_cnt = rate_ticks(act.rate);
               if (one_shot) begin
                  next_one_shot = 1'h0;
                  next_mst      = alc_pkg::M_IDLE;
               end else if (act.cont) begin
                  next_acc      = '0;
                  next_conv_cnt = 8'h00;
                  next_mst      = act.offs ? alc_pkg::M_DARK : alc_pkg::M_CONV;
               end else begin
                  next_mst = alc_pkg::M_WAIT;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mst            <= alc_pkg::M_IDLE;
         act            <= alc_pkg::ALC_PARAMS_RST;
         acc            <= '0;
         dark           <= '0;
         conv_cnt       <= 8'h00;
         tick_cnt       <= 32'h0;
         wait_cnt       <= 7'h00;
         one_shot       <= 1'h0;
         adc_start      <= 1'h0;
         adc_dark       <= 1'h0;
         ambient_result <= '0;
         ambient_ready  <= 1'h0;
         osc_en         <= 1'h0;
      end else begin
         mst            <= next_mst;
         act            <= next_act;
         acc            <= next_acc;
         dark           <= next_dark;
         conv_cnt       <= next_conv_cnt;
         tick_cnt       <= next_tick_cnt;
         wait_cnt       <= next_wait_cnt;
         one_shot       <= next_one_shot;
         adc_start      <= next_adc_start;
         adc_dark       <= next_adc_dark;
         ambient_result <= next_result;
         ambient_ready  <= next_ready;
         osc_en         <= selftimed_en;
      end
   end

endmodule // alc_ctrl

// ===== alc_host_model.sv
// Host model for the two-wire serial bus of the ambient parameter register.
// Assumes pull-ups on both wires and a 50 MHz clock to pace the bit phases.
`timescale 1ns/1ps

module alc_host #(
   parameter logic [6:0] ADDR = 7'h2A  // Arbitrary value
) (
   // Clock
   input  wire logic clock,
   // Bus wires
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_drv
);
   initial begin
      scl = 1'h1;
      sda_drv = 1'h1;
   end
   // Ten clocks a phase keeps each level well above the three-clock synchroniser delay
   task automatic hold();
      repeat (10) @(negedge clock);
   endtask
   task automatic bit_io(input logic b, output logic r);
      hold();
      sda_drv = b;
      hold();
      scl = 1'h1;
      hold();
      r = sda_line;
      scl = 1'h0;
   endtask
   task automatic start();
      hold();
      sda_drv = 1'h1;
      hold();
      scl = 1'h1;
      hold();
      sda_drv = 1'h0;
      hold();
      scl = 1'h0;
   endtask
   task automatic stop();
      hold();
      sda_drv = 1'h0;
      hold();
      scl = 1'h1;
      hold();
      sda_drv = 1'h1;
      hold();
   endtask
   task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(m, a);
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
      logic [7:0] x;
      logic       a0, a1, a2;
      start();
      xfer({ADDR, 1'h0}, 1'h1, x, a0);
      xfer(p, 1'h1, x, a1);
      xfer(d, 1'h1, x, a2);
      stop();
      ok = !(a0 | a1 | a2);
   endtask
   // Pointer set by a write phase, then a repeated start and one byte with NACK
   task automatic rd(input logic [7:0] p, output logic [7:0] q);
      logic [7:0] x;
      logic       a;
      start();
      xfer({ADDR, 1'h0}, 1'h1, x, a);
      xfer(p, 1'h1, x, a);
      start();
      xfer({ADDR, 1'h1}, 1'h1, x, a);
      xfer(8'hFF, 1'h1, q, a);
      stop();
   endtask
endmodule // alc_host

// ===== alc_monitor.sv
// Checker for the ambient light conversion control ports.
// Assumes one clock domain; bound onto every alc_ctrl instance.
`timescale 1ns/1ps

module alc_monitor #(
   parameter int ADC_WIDTH = 16
) (
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 rst_b,
   // Observed ports
   input  wire logic                 scl_in,
   input  wire logic                 sda_oe,
   input  wire logic                 selftimed_en,
   input  wire logic                 als_en,
   input  wire logic                 adc_start,
   input  wire logic                 adc_dark,
   input  wire logic                 adc_done,
   input  wire logic                 osc_en,
   input  wire logic [ADC_WIDTH-1:0] ambient_result,
   input  wire logic                 ambient_ready
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   sequence s_conv_busy;
      !adc_start [*3];
   endsequence
   sequence s_amb_start;
      adc_start && !adc_dark;
   endsequence
   a_osc_follows_enable: assert property (osc_en == $past(selftimed_en)) else $error("osc enable wrong");
   a_no_start_disabled: assert property ((selftimed_en && !als_en) [*8] |-> !adc_start) else $error("start unasked");
   a_start_waits_done: assert property (adc_start |=> s_conv_busy) else $error("start too soon");
   a_dark_then_amb: assert property (adc_start && adc_dark |-> ##[2:20] s_amb_start) else $error("no ambient");
   a_dark_flag_stable: assert property (adc_start |=> $stable(adc_dark) [*2]) else $error("dark flag moved");
   a_ready_after_done: assert property (ambient_ready |-> $past(adc_done, 2)) else $error("ready uncaused");
   a_ready_one_cycle: assert property (ambient_ready |=> !ambient_ready) else $error("ready too long");
   a_result_held: assert property (!ambient_ready |-> $stable(ambient_result)) else $error("result moved");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved on high scl");
endmodule // alc_monitor

bind alc_ctrl alc_monitor #(.ADC_WIDTH(ADC_WIDTH)) i_mon (.clock, .rst_b, .scl_in, .sda_oe, .selftimed_en, .als_en,
   .adc_start, .adc_dark, .adc_done, .osc_en, .ambient_result, .ambient_ready);

// ===== alc_pkg.sv
// Constants and types shared by the ambient light conversion control block.
// Assumes a 50 MHz system clock and a two-wire serial host outside.
package alc_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] ALC_PARAM_OFFSET = 8'h84;
   localparam logic [7:0] ALC_UNMAPPED_RD  = 8'h00;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int ALC_CONT_POS = 7;
   localparam int ALC_RATE_POS = 4;
   localparam int ALC_OFFS_POS = 3;
   localparam int ALC_AVG_POS  = 0;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic       ALC_CONT_RST = 1'h0;
   localparam logic [2:0] ALC_RATE_RST = 3'h1;
   localparam logic       ALC_OFFS_RST = 1'h1;
   localparam logic [2:0] ALC_AVG_RST  = 3'h5;

   // ****************************************
   // Timing
   // ****************************************
   localparam int ALC_CLOCK_HZ       = 50_000_000;
   localparam int ALC_BASE_TICK_HZ   = 120;
   localparam int ALC_BASE_TICK_CYC  = ALC_CLOCK_HZ / ALC_BASE_TICK_HZ;

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic       cont;
      logic [2:0] rate;
      logic       offs;
      logic [2:0] avg;
   } alc_params_t;

   localparam alc_params_t ALC_PARAMS_RST = '{cont: ALC_CONT_RST, rate: ALC_RATE_RST,
                                              offs: ALC_OFFS_RST, avg: ALC_AVG_RST};

   typedef enum logic [2:0] {I_IDLE, I_ADDR, I_PTR, I_WR, I_RD} alc_bus_state_t;
   typedef enum logic [2:0] {M_IDLE, M_WAIT, M_DARK, M_DARK_W, M_CONV, M_CONV_W, M_STORE} alc_meas_state_t;

endpackage

// ===== tb.sv
// Testbench for alc_ctrl: host model on the wires, converter model here.
// Assumes a short tick parameter so rate gaps stay a few hundred cycles.
`timescale 1ns/1ps

module tb;
   // ****************************************
   // Signals
   // ****************************************
   localparam int TICK = 4;
   logic        clock, rst_b, selftimed_en, als_en, one_shot, ok, scl, host_sda;
   logic        sda_out, sda_oe, adc_start, adc_dark, osc_en, ambient_ready, sda_line;
   logic        adc_done = 1'h0;
   logic [1:0]  pend = 2'h0;
   logic [7:0]  q;
   logic [15:0] adc_data = 16'h0, cyc = 16'h0, last = 16'h0, gap = 16'h0, rdy_n = 16'h0;
   logic [15:0] dark_n = 16'h0, amb_n = 16'h0, ambient_result, d0, a0;
   int          bad_count = 0, checks = 0;
   int          tk [8] = '{120, 60, 40, 30, 24, 20, 15, 12};
   logic [7:0]  par [3] = '{8'h1A, 8'h07, 8'h19};
   logic [15:0] dk [3] = '{16'h1, 16'h0, 16'h1};
   logic [15:0] am [3] = '{16'h4, 16'h80, 16'h2};
   logic [15:0] rs [3] = '{16'h00D1, 16'h0101, 16'h00D1};
   assign sda_line = host_sda & ~sda_oe;
   alc_host i_host (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_drv(host_sda));
   alc_ctrl #(.TICK_CYC(TICK)) i_dut (.clock(clock), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .selftimed_en(selftimed_en), .als_en(als_en),
      .ambient_one_shot_request(one_shot), .adc_start(adc_start), .adc_dark(adc_dark), .adc_done(adc_done),
      .adc_data(adc_data), .osc_en(osc_en), .ambient_result(ambient_result), .ambient_ready(ambient_ready));
   // Converter answers three cycles after start; ambient values alternate so averaging shows
   always @(negedge clock) begin
      adc_done <= 1'h0;
      if (pend == 2'h1) begin
         adc_done <= 1'h1;
         adc_data <= adc_dark ? 16'h0030 : 16'h0100 | {14'h0, amb_n[0], 1'h0};
      end
      if (pend != 2'h0) pend <= pend - 2'h1;
      if (adc_start === 1'h1) begin
         pend <= 2'h3;
         if (adc_dark === 1'h1) dark_n <= dark_n + 16'h1;
         else amb_n <= amb_n + 16'h1;
      end
   end
   always @(posedge clock) begin
      cyc <= cyc + 16'h1;
      if (ambient_ready === 1'h1) begin
         gap <= cyc - last;
         last <= cyc;
         rdy_n <= rdy_n + 16'h1;
      end
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic wait_rdy(input int k);
      logic [15:0] goal;
      int          n;
      goal = rdy_n + 16'(k);
      n = 0;
      while (rdy_n !== goal && n < 5000) begin
         @(negedge clock);
         n++;
      end
      chk(16'(n < 5000), 16'h1, "no reading");
   endtask
   task automatic run(input logic on);
      selftimed_en = on;
      als_en = on;
      repeat (10) @(negedge clock);
   endtask
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      clock = 1'h0;
      forever #10 clock = ~clock;
   end
   initial begin
      repeat (60000) @(posedge clock);
      bad_count++;
      complete_run();
   end
   initial begin
      rst_b = 1'h0;
      selftimed_en = 1'h0;
      als_en = 1'h0;
      one_shot = 1'h0;
      repeat (12) @(negedge clock);
      rst_b = 1'h1;
      repeat (4) @(negedge clock);
      i_host.rd(8'h84, q);
      chk(16'(q), 16'h001D, "reset value");
      chk(16'(sda_out), 16'h0000, "sda drive level");
      i_host.wr(8'h85, 8'h55, ok);
      chk(16'(ok), 16'h1, "no ack");
      i_host.rd(8'h84, q);
      chk(16'(q), 16'h001D, "stray write");
      i_host.rd(8'h85, q);
      chk(16'(q), 16'h0000, "unmapped read");
      $display("test registers done");
      selftimed_en = 1'h1;
      d0 = dark_n + amb_n;
      repeat (100) @(negedge clock);
      chk(dark_n + amb_n, d0, "started without enable");
      chk(16'(osc_en), 16'h1, "oscillator off");
      als_en = 1'h1;
      wait_rdy(1);
      run(1'h0);
      $display("test enable done");
      for (int i = 0; i < 3; i++) begin
         i_host.wr(8'h84, par[i], ok);
         i_host.rd(8'h84, q);
         chk(16'(q), 16'(par[i]), "readback");
         d0 = dark_n;
         a0 = amb_n;
         one_shot = 1'h1;
         @(negedge clock);
         one_shot = 1'h0;
         wait_rdy(1);
         chk(dark_n - d0, dk[i], "dark count");
         chk(amb_n - a0, am[i], "conversion count");
         chk(ambient_result, rs[i], "result");
      end
      $display("test one shot done");
      for (int r = 0; r < 8; r++) begin
         run(1'h0);
         i_host.wr(8'h84, {1'h0, 3'(r), 4'h0}, ok);
         run(1'h1);
         wait_rdy(2);
         chk(16'(gap >= tk[r] * TICK && gap <= tk[r] * TICK + 20), 16'h1, "rate gap");
      end
      $display("test rates done");
      i_host.wr(8'h84, 8'hF0, ok);
      wait_rdy(2);
      chk(16'(gap >= 12 * TICK), 16'h1, "applied during run");
      i_host.rd(8'h84, q);
      chk(16'(q), 16'h00F0, "shadow readback");
      run(1'h0);
      run(1'h1);
      wait_rdy(2);
      chk(16'(gap <= 20), 16'h1, "continuous gap");
      run(1'h0);
      $display("test deferral done");
      complete_run();
   end
endmodule // tb
